/* File: hw/bgf_map.vh */
/*
 Constants for the board-side pin controller: register offsets, field
 positions, reset values and pin numbers of the host GPIO port.
 Assumes a 200 MHz clock and a 28-pin GPIO port seen from the board.
*/
// Contract
// - radio drives its interrupt high to request, low for none
// - one data pin shared by codec control bus and battery bus
// - one clock pin shared by codec control bus and battery bus
// - stereo codec external clock arrives on a dedicated input pin
// - user supplies radio port clock; pin is spare without radio
// - pin carries bus grant with companion, card interrupt otherwise; the code drives card interrupt only with neither module fitted
// - pin carries bus request with companion, card detect otherwise; the code drives card detect only with neither module fitted
// - pin carries graphics interrupt, else card battery status b; the code drives battery status b only with neither module fitted
// - pin carries companion interrupt, else card battery status a; the code drives battery status a only with neither module fitted
// - touch codec signals all its events on one shared interrupt pin
`ifndef BGF_MAP_VH
`define BGF_MAP_VH
`define BGF_NPIN 28
// register offsets
`define BGF_REG_CTRL 4'h0
`define BGF_REG_EVENT 4'h4
`define BGF_REG_DIV 4'h8
`define BGF_REG_STATUS 4'hC
// control fields
`define BGF_CTRL_COMPANION 0
`define BGF_CTRL_GRAPHICS 1
`define BGF_CTRL_RADIO 2
`define BGF_CTRL_CODEC_CLK 3
`define BGF_CTRL_RADIO_CLK 4
`define BGF_CTRL_RST 5'h00
// event fields
`define BGF_EV_RADIO_IRQ 0
`define BGF_EV_TOUCH_IRQ 1
`define BGF_EV_GFX_IRQ 2
`define BGF_EV_COMP_IRQ 3
`define BGF_EV_CARD_IRQ 4
`define BGF_EV_CD_A 5
`define BGF_EV_CD_B 6
`define BGF_EV_BATT_A 7
`define BGF_EV_BATT_B 8
`define BGF_EV_BUS_REQ 9
`define BGF_EV_SDA_LOW 10
`define BGF_EV_SCL_LOW 11
`define BGF_EV_RST 12'h060
// divider reset: half periods minus one, in clk cycles
`define BGF_DIV_RST 32'h0004_0004
// pin numbers
`define BGF_PIN_RADIO_IRQ 14
`define BGF_PIN_SDA 15
`define BGF_PIN_SCL 18
`define BGF_PIN_CODEC_CLK 19
`define BGF_PIN_RADIO_CLK 20
`define BGF_PIN_GRANT 21
`define BGF_PIN_REQ 22
`define BGF_PIN_TOUCH 23
`define BGF_PIN_GFX 24
`define BGF_PIN_COMP 25
`endif

/* File: hw/bgf_host.v */
/*
 Board-side controller for the host GPIO port: drives interrupts, clocks,
 card signals and the shared open-drain serial lines onto the pins, and
 shows the filtered pin levels to software through a small register port.
 Assumes the pins are resolved by the bench from out and enable, and that
 the processor side drives its own outputs (power level, selects, clocks).
*/
`include "bgf_map.vh"
`timescale 1ns/100ps
`default_nettype none

module bgf_host
(
   input wire clk,
   input wire resetn,
   input wire [3:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   input wire [27:0] gp_in,
   output reg [27:0] gp_out,
   output reg [27:0] gp_oe
);

   reg [4:0] ctrl_r;
   reg [11:0] event_r;
   reg [31:0] div_r;
   reg [27:0] sync1_r;
   reg [27:0] sync2_r;
   reg [27:0] sync3_r;
   reg [27:0] level_r;
   reg [15:0] ccnt_r;
   reg [15:0] rcnt_r;
   reg cclk_r;
   reg rclk_r;
   reg [27:0] out_nxt;
   reg [27:0] oe_nxt;
   wire companion;
   wire no_daughter;

   // one step of a half-period counter; wraps at the programmed limit
   function [15:0] div_step;
      input [15:0] cnt;
      input [15:0] lim;
      begin
         if (cnt >= lim)
            div_step = 16'h0000;
         else
            div_step = cnt + 16'h0001;
      end
   endfunction

   assign companion = ctrl_r[`BGF_CTRL_COMPANION];
   // no daughter board means neither module is fitted
   assign no_daughter = ~companion & ~ctrl_r[`BGF_CTRL_GRAPHICS];

   // register writes; software owns every board-side source level
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_r <= `BGF_CTRL_RST;
         event_r <= `BGF_EV_RST;
         div_r <= `BGF_DIV_RST;
      end
      else if (wr)
      begin
         if (addr == `BGF_REG_CTRL)
            ctrl_r <= wdata[4:0];
         else if (addr == `BGF_REG_EVENT)
            event_r <= wdata[11:0];
         else if (addr == `BGF_REG_DIV)
            div_r <= wdata;
      end
   end

   // read port; data stand in the cycle after the strobe only
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rdata <= 32'h0000_0000;
      else if (rd)
      begin
         if (addr == `BGF_REG_CTRL)
            rdata <= {27'h0000000, ctrl_r};
         else if (addr == `BGF_REG_EVENT)
            rdata <= {20'h00000, event_r};
         else if (addr == `BGF_REG_DIV)
            rdata <= div_r;
         else if (addr == `BGF_REG_STATUS)
            rdata <= {4'h0, level_r};
         else
            rdata <= 32'h0000_0000;
      end
      else
         rdata <= 32'h0000_0000;
   end

   // three-stage pin sampling; a high counts only once stages two and three
   // agree, so a single high sample never reaches software but a single low one does
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_r <= 28'h0000000;
         sync2_r <= 28'h0000000;
         sync3_r <= 28'h0000000;
         level_r <= 28'h0000000;
      end
      else
      begin
         sync1_r <= gp_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         level_r <= (sync2_r & sync3_r) | (level_r & ~(sync2_r ^ sync3_r));
      end
   end

   // clock generators for the codec external clock and radio port clock
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ccnt_r <= 16'h0000;
         rcnt_r <= 16'h0000;
         cclk_r <= 1'b0;
         rclk_r <= 1'b0;
      end
      else
      begin
         ccnt_r <= div_step(ccnt_r, div_r[15:0]);
         rcnt_r <= div_step(rcnt_r, div_r[31:16]);
         if (!ctrl_r[`BGF_CTRL_CODEC_CLK])
            cclk_r <= 1'b0;
         else if (ccnt_r >= div_r[15:0])
            cclk_r <= ~cclk_r;
         if (!ctrl_r[`BGF_CTRL_RADIO_CLK] || !ctrl_r[`BGF_CTRL_RADIO])
            rclk_r <= 1'b0;
         else if (rcnt_r >= div_r[31:16])
            rclk_r <= ~rclk_r;
      end
   end

   // pin drive; pins the processor owns stay undriven here, including
   // the top two, the strap byte and both switch pins
   always @*
   begin
      out_nxt = 28'h0000000;
      oe_nxt = 28'h0000000;
      // radio interrupt exists only with the radio fitted
      if (ctrl_r[`BGF_CTRL_RADIO])
      begin
         oe_nxt[`BGF_PIN_RADIO_IRQ] = 1'b1;
         out_nxt[`BGF_PIN_RADIO_IRQ] = event_r[`BGF_EV_RADIO_IRQ];
      end
      // open drain: only ever pull low, never drive high
      oe_nxt[`BGF_PIN_SDA] = event_r[`BGF_EV_SDA_LOW];
      oe_nxt[`BGF_PIN_SCL] = event_r[`BGF_EV_SCL_LOW];
      oe_nxt[`BGF_PIN_CODEC_CLK] = ctrl_r[`BGF_CTRL_CODEC_CLK];
      out_nxt[`BGF_PIN_CODEC_CLK] = cclk_r;
      oe_nxt[`BGF_PIN_RADIO_CLK] = ctrl_r[`BGF_CTRL_RADIO_CLK]
                                   & ctrl_r[`BGF_CTRL_RADIO];
      out_nxt[`BGF_PIN_RADIO_CLK] = rclk_r;
      // grant is the processor's output with either module fitted; card irq with neither
      if (no_daughter)
      begin
         oe_nxt[`BGF_PIN_GRANT] = 1'b1;
         out_nxt[`BGF_PIN_GRANT] = event_r[`BGF_EV_CARD_IRQ];
      end
      // request from the companion, combined card detect with neither module
      if (companion)
      begin
         oe_nxt[`BGF_PIN_REQ] = 1'b1;
         out_nxt[`BGF_PIN_REQ] = event_r[`BGF_EV_BUS_REQ];
      end
      else if (no_daughter)
      begin
         oe_nxt[`BGF_PIN_REQ] = 1'b1;
         // AND of both detects: low while a card sits in the socket
         out_nxt[`BGF_PIN_REQ] = event_r[`BGF_EV_CD_A]
                                 & event_r[`BGF_EV_CD_B];
      end
      // one line carries every touch codec event
      oe_nxt[`BGF_PIN_TOUCH] = 1'b1;
      out_nxt[`BGF_PIN_TOUCH] = event_r[`BGF_EV_TOUCH_IRQ];
      oe_nxt[`BGF_PIN_GFX] = 1'b1;
      if (no_daughter)
         out_nxt[`BGF_PIN_GFX] = event_r[`BGF_EV_BATT_B];
      else
         out_nxt[`BGF_PIN_GFX] = event_r[`BGF_EV_GFX_IRQ];
      oe_nxt[`BGF_PIN_COMP] = 1'b1;
      if (no_daughter)
         out_nxt[`BGF_PIN_COMP] = event_r[`BGF_EV_BATT_A];
      else
         out_nxt[`BGF_PIN_COMP] = event_r[`BGF_EV_COMP_IRQ];
   end

   // registered pin outputs; adds one cycle of latency to every source
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         gp_out <= 28'h0000000;
         gp_oe <= 28'h0000000;
      end
      else
      begin
         gp_out <= out_nxt;
         gp_oe <= oe_nxt;
      end
   end

endmodule

`default_nettype wire

/* File: verif/bgf_host_sva.sv */
/* port checker for the board pin controller
   assumes one clock domain; bound from the bench top file */
`timescale 1ns/100ps
`default_nettype none
module bgf_host_chk
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic [27:0] gp_out,
   input wire logic [27:0] gp_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // register writes reach the pins two edges after the strobe
   wire ev_w = wr && addr == 4'h4;
   wire ct_w = wr && addr == 4'h0;
   spare_pins_a: assert property (
      (gp_oe & 28'hC033FFF) == 28'h0)
      else $error("processor-owned pin driven");
   od_low_a: assert property (
      gp_out[15] == 1'b0 && gp_out[18] == 1'b0)
      else $error("open drain line driven high");
   sda_pull_a: assert property (
      ev_w |-> ##2 gp_oe[15] == $past(wdata[10], 2))
      else $error("data line pull wrong");
   scl_pull_a: assert property (
      ev_w |-> ##2 gp_oe[18] == $past(wdata[11], 2))
      else $error("clock line pull wrong");
   touch_drive_a: assert property ($past(resetn) |-> gp_oe[23])
      else $error("touch interrupt pin undriven");
   radio_drive_a: assert property (
      ct_w |-> ##2 gp_oe[14] == $past(wdata[2], 2))
      else $error("radio interrupt drive wrong");
   grant_free_a: assert property (
      ct_w |-> ##2
      gp_oe[21] == !($past(wdata[0], 2) || $past(wdata[1], 2)))
      else $error("grant pin drive wrong");
   req_drive_a: assert property (
      ct_w |-> ##2
      gp_oe[22] == ($past(wdata[0], 2) || !$past(wdata[1], 2)))
      else $error("request pin drive wrong");
   // enabled clock pins must keep toggling; the bench never programs a
   // half period above five cycles
   codec_clk_a: assert property (
      gp_oe[19] |-> ##[1:8] (!gp_oe[19] || $changed(gp_out[19])))
      else $error("codec clock pin stuck");
   radio_clk_a: assert property (
      gp_oe[20] |-> ##[1:8] (!gp_oe[20] || $changed(gp_out[20])))
      else $error("radio clock pin stuck");
endmodule
`default_nettype wire

/* File: verif/bgf_proc_model.sv */
/* processor side of the shared pins: resolves every pin level
   assumes the bench supplies the processor's own pin values */
`timescale 1ns/100ps
`default_nettype none
module bgf_proc_model
(
   input wire logic [27:0] gp_out,
   input wire logic [27:0] gp_oe,
   input wire logic [27:0] proc_val,
   output logic [27:0] gp_in
);
   // board drives where enabled; the processor holds the rest
   always_comb
   begin
      gp_in = (gp_out & gp_oe) | (proc_val & ~gp_oe);
      // pins only the processor drives: switches, straps, supply, select
      gp_in[1:0] = proc_val[1:0];
      gp_in[9:2] = proc_val[9:2];
      gp_in[16] = proc_val[16];
      gp_in[17] = proc_val[17];
      gp_in[26] = proc_val[26];
      gp_in[27] = proc_val[27];
      // shared lines float high through pull-ups unless pulled low
      gp_in[15] = gp_oe[15] ? gp_out[15] : 1'b1;
      gp_in[18] = gp_oe[18] ? gp_out[18] : 1'b1;
   end
endmodule
`default_nettype wire

/* File: verif/bgf_host_tb.sv */
/* self-checking bench for the board pin controller
   assumes the processor model and the port checker */
`include "bgf_map.vh"
`timescale 1ns/100ps
`default_nettype none
module bgf_host_tb;
   logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [27:0] proc_val = 28'h0, pr;
   logic [4:0] cr;
   logic [11:0] er;
   logic [63:0] notes[$], nt;
   wire [31:0] rdata;
   wire [27:0] gp_in, gp_out, gp_oe;
   int n_fail = 0, samples_checked = 0, i;
   bgf_host uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .gp_in(gp_in), .gp_out(gp_out),
      .gp_oe(gp_oe));
   bgf_proc_model peer (.gp_out(gp_out), .gp_oe(gp_oe),
      .proc_val(proc_val), .gp_in(gp_in));
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   // expected pin levels; clock pins 19 and 20 are masked off
   function automatic logic [27:0] exp_pins(input logic [4:0] c,
      input logic [11:0] e, input logic [27:0] p);
      logic nd;
      logic [27:0] d;
      nd = !c[0] && !c[1];
      d = p;
      if (c[2]) d[14] = e[0];
      d[15] = !e[10];
      d[18] = !e[11];
      if (nd) d[21] = e[4];
      if (c[0]) d[22] = e[9];
      else if (!c[1]) d[22] = e[5] & e[6];
      d[23] = e[1];
      d[24] = nd ? e[8] : e[2];
      d[25] = nd ? e[7] : e[3];
      return d;
   endfunction
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // the note is queued with the strobe and popped by the monitor
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] x,
      input logic [31:0] m);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      notes.push_back({m, x});
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic cmp(input logic [31:0] got, x, m);
      samples_checked++;
      if ((got & m) !== (x & m))
      begin
         n_fail++;
         $display("unexpected t=%0t got %h exp %h", $time, got & m, x & m);
      end
   endtask
   task automatic finish_test;
      if (n_fail == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge clk)
   begin
      rd_q <= rd;
      if (rd_q && notes.size() > 0)
      begin
         nt = notes.pop_front();
         cmp(rdata, nt[31:0], nt[63:32]);
      end
   end
   initial
   begin
      void'($urandom(32'hEAF3FF3C));
      pr = $urandom;
      proc_val <= pr;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rd_chk(`BGF_REG_CTRL, 32'h0, 32'hFFFFFFFF);
      rd_chk(4'h2, 32'h0, 32'hFFFFFFFF);
      rd_chk(`BGF_REG_EVENT, `BGF_EV_RST, 32'hFFFFFFFF);
      rd_chk(`BGF_REG_DIV, `BGF_DIV_RST, 32'hFFFFFFFF);
      rd_chk(`BGF_REG_STATUS, {4'h0, exp_pins(5'h0, 12'h060, pr)},
         32'h0FE7FFFF);
      wr_reg(`BGF_REG_DIV, 32'h00030002);
      rd_chk(`BGF_REG_DIV, 32'h00030002, 32'hFFFFFFFF);
      // random attachment, events and processor levels cover every mode
      for (i = 0; i < 40; i++)
      begin
         cr = $urandom;
         er = $urandom;
         pr = $urandom;
         wr_reg(`BGF_REG_CTRL, {27'h0, cr});
         wr_reg(`BGF_REG_EVENT, {20'h0, er});
         proc_val <= pr;
         repeat (8) @(posedge clk);
         rd_chk(`BGF_REG_EVENT, {20'h0, er}, 32'hFFFFFFFF);
         rd_chk(`BGF_REG_STATUS, {4'h0, exp_pins(cr, er, pr)},
            32'h0FE7FFFF);
      end
      for (i = 0; i < 50 && notes.size() > 0; i++)
         @(posedge clk);
      if (notes.size() > 0)
         n_fail++;
      finish_test();
   end
endmodule
bind bgf_host bgf_host_chk chk (.clk(clk), .resetn(resetn), .addr(addr),
   .wdata(wdata), .wr(wr), .gp_out(gp_out), .gp_oe(gp_oe));
`default_nettype wire
